// ===== logic/pcw_map.svh
`ifndef PCW_MAP_SVH
`define PCW_MAP_SVH

// ***************************************
// register offsets
// ***************************************
`define PCW_OFS_RANGE0   8'h00
`define PCW_OFS_RANGE1   8'h04
`define PCW_OFS_BASE0    8'h08
`define PCW_OFS_BASE1    8'h0c
`define PCW_OFS_ENH1     8'h10
`define PCW_OFS_ENH2     8'h14
`define PCW_OFS_STATUS   8'h18

// ***************************************
// field positions
// ***************************************
`define PCW_RANGE_ACKMSK 0
`define PCW_RANGE_IO_WINDOW_ENABLE   1
`define PCW_RANGE_MSK_LO 3
`define PCW_RANGE_MSK_HI 7
`define PCW_ENH1_GLOBAL  7
`define PCW_ENH2_ATA     1

// ***************************************
// reset values and write masks
// ***************************************
`define PCW_RST_RANGE    8'h00
`define PCW_RST_BASE     16'h0000
`define PCW_RST_ENH      8'h00
`define PCW_WMASK_RANGE  8'hfb
`define PCW_WMASK_ENH2   8'h1f

// ***************************************
// timing
// ***************************************
`define PCW_CLK_NS       50
`define PCW_LEGACY_NS    70
`define PCW_RELAXED_NS   55
`define PCW_LEGACY_CYC   ((`PCW_LEGACY_NS + `PCW_CLK_NS - 1) / `PCW_CLK_NS)
`define PCW_RELAXED_CYC  ((`PCW_RELAXED_NS + `PCW_CLK_NS - 1) / `PCW_CLK_NS)

`endif

// ===== logic/pcw_pkg.sv
package pcw_pkg;

	typedef logic [15:0] pcw_addr_type;

	typedef enum logic [1:0] {
		CYC_IDLE   = 2'b00,
		CYC_SELECT = 2'b01,
		CYC_MISS   = 2'b11
	} pcw_cyc_type;

endpackage

// ===== logic/pcw_io16_sampler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcw_map.svh"

module pcw_io16_sampler (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// timing anchors and mode
	input  wire logic relaxed,
	input  wire logic addrAnchor,
	input  wire logic selAnchor,
	// card indication, active low
	input  wire logic ioIs16_n,
	// sampled result
	output logic      sampleValid,
	output logic      sampleWide
);
	import pcw_pkg::*;

	logic [2:0] count;
	logic [2:0] next_count;
	logic [2:0] limit;
	logic       anchor;
	logic       next_sampleValid;
	logic       next_sampleWide;

	// ***************************************
	// sample point counter
	// ***************************************
	always_comb begin
		anchor = relaxed ? selAnchor : addrAnchor;
		limit = relaxed ? 3'(`PCW_RELAXED_CYC) : 3'(`PCW_LEGACY_CYC);
		next_count = count;
		next_sampleValid = 1'b0;
		next_sampleWide = sampleWide;
		if (!anchor) begin
			next_count = 3'h0;
		end else if (count == limit - 3'h1) begin
			next_sampleValid = 1'b1;
			next_sampleWide = !ioIs16_n;
			next_count = count + 3'h1;
		end else if (count < limit) begin
			next_count = count + 3'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count <= 3'h0;
			sampleValid <= 1'b0;
			sampleWide <= 1'b0;
		end else begin
			count <= next_count;
			sampleValid <= next_sampleValid;
			sampleWide <= next_sampleWide;
		end
	end

endmodule

`default_nettype wire

// ===== logic/pcw_io_window_decode.sv
// Operation
// - mask bits 7..3 drop address bits from compare; windows 8..256 bytes; reset zero
// - ack mask 0: ignore card ack, buffers follow chip select
// - ack mask 1: card input acknowledge is honoured
// - honoured ack: buffers on only with chip select and card ack
// - relaxed mode samples 16-bit indication 55 ns after chip select
// - relaxed sampling only with enhancement bits D1 of enh2 and global D7 of enh1 both set, else legacy
// - window enable bit switches each slot's window on or off
// - enhancement bits cleared by reset, legacy behaviour at start
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcw_map.svh"

module pcw_io_window_decode (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// axi4-lite write address and data
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// host i/o cycle
	input  wire logic                 ioCycle,
	input  wire pcw_pkg::pcw_addr_type ioAddr,
	// card slots
	output logic [1:0]                cardSelect_n,
	input  wire logic [1:0]           inputAck_n,
	output logic [1:0]                dataBufEnable,
	input  wire logic [1:0]           ioIs16_n,
	output logic [1:0]                io16Valid,
	output logic [1:0]                io16Wide
);
	import pcw_pkg::*;

	// ***************************************
	// decode functions
	// ***************************************
	function automatic logic [2:0] regIndex(input logic [7:0] a);
		regIndex = 3'h7;
		unique case (a)
			`PCW_OFS_RANGE0: regIndex = 3'h0;
			`PCW_OFS_RANGE1: regIndex = 3'h1;
			`PCW_OFS_BASE0:  regIndex = 3'h2;
			`PCW_OFS_BASE1:  regIndex = 3'h3;
			`PCW_OFS_ENH1:   regIndex = 3'h4;
			`PCW_OFS_ENH2:   regIndex = 3'h5;
			`PCW_OFS_STATUS: regIndex = 3'h6;
			default:         regIndex = 3'h7;
		endcase
	endfunction

	function automatic logic windowHit(input pcw_addr_type a, input pcw_addr_type b,
		input logic [7:0] r);
		pcw_addr_type care;
		care = {8'hff, ~r[`PCW_RANGE_MSK_HI:`PCW_RANGE_MSK_LO], 3'h0};
		windowHit = ((a ^ b) & care) == 16'h0000;
	endfunction

	// ***************************************
	// register state
	// ***************************************
	logic [7:0]   rangeReg [2];
	logic [7:0]   next_rangeReg [2];
	pcw_addr_type baseReg [2];
	pcw_addr_type next_baseReg [2];
	logic [7:0]   enh1;
	logic [7:0]   next_enh1;
	logic [7:0]   enh2;
	logic [7:0]   next_enh2;
	logic         relaxedEn;

	logic         awHeld;
	logic         next_awHeld;
	logic [7:0]   awAddr;
	logic [7:0]   next_awAddr;
	logic         wHeld;
	logic         next_wHeld;
	logic [31:0]  wData;
	logic [31:0]  next_wData;
	logic [3:0]   wStrb;
	logic [3:0]   next_wStrb;
	logic         next_bvalid;
	logic [1:0]   next_bresp;
	logic         next_rvalid;
	logic [1:0]   next_rresp;
	logic [31:0]  next_rdata;
	logic [31:0]  readMux;
	logic [2:0]   wIdx;

	pcw_cyc_type  cycState;
	pcw_cyc_type  next_cycState;
	logic [1:0]   next_cardSelect_n;
	logic [1:0]   claimHit;

	assign relaxedEn = enh1[`PCW_ENH1_GLOBAL] && enh2[`PCW_ENH2_ATA];
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// ***************************************
	// bus slave and registers
	// ***************************************
	always_comb begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld = wHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rangeReg = rangeReg;
		next_baseReg = baseReg;
		next_enh1 = enh1;
		next_enh2 = enh2;
		wIdx = regIndex(awAddr);
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (awHeld && wHeld) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wIdx == 3'h7) ? 2'h2 : 2'h0;
			unique case (wIdx)
				3'h0, 3'h1: begin
					if (wStrb[0]) begin
						next_rangeReg[wIdx[0]] = wData[7:0] & `PCW_WMASK_RANGE;
					end
				end
				3'h2, 3'h3: begin
					if (wStrb[0]) begin
						next_baseReg[wIdx[0]][7:0] = wData[7:0];
					end
					if (wStrb[1]) begin
						next_baseReg[wIdx[0]][15:8] = wData[15:8];
					end
				end
				3'h4: begin
					if (wStrb[0]) begin
						next_enh1 = wData[7:0];
					end
				end
				3'h5: begin
					if (wStrb[0]) begin
						next_enh2 = wData[7:0] & `PCW_WMASK_ENH2;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		readMux = 32'h0000_0000;
		unique case (regIndex(s_axi_araddr))
			3'h0:    readMux = {24'h000000, rangeReg[0]};
			3'h1:    readMux = {24'h000000, rangeReg[1]};
			3'h2:    readMux = {16'h0000, baseReg[0]};
			3'h3:    readMux = {16'h0000, baseReg[1]};
			3'h4:    readMux = {24'h000000, enh1};
			3'h5:    readMux = {24'h000000, enh2};
			3'h6:    readMux = {24'h000000, cycState, ~cardSelect_n, 2'h0, io16Wide};
			default: readMux = 32'h0000_0000;
		endcase
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata = readMux;
			next_rresp = (regIndex(s_axi_araddr) == 3'h7) ? 2'h2 : 2'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rangeReg <= '{`PCW_RST_RANGE, `PCW_RST_RANGE};
			baseReg <= '{`PCW_RST_BASE, `PCW_RST_BASE};
			enh1 <= `PCW_RST_ENH;
			enh2 <= `PCW_RST_ENH;
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			wHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			rangeReg <= next_rangeReg;
			baseReg <= next_baseReg;
			enh1 <= next_enh1;
			enh2 <= next_enh2;
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld <= next_wHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// ***************************************
	// window claim and chip select
	// ***************************************
	always_comb begin
		claimHit[0] = rangeReg[0][`PCW_RANGE_IO_WINDOW_ENABLE]
			&& windowHit(ioAddr, baseReg[0], rangeReg[0]);
		claimHit[1] = rangeReg[1][`PCW_RANGE_IO_WINDOW_ENABLE] && !claimHit[0]
			&& windowHit(ioAddr, baseReg[1], rangeReg[1]);
		next_cycState = cycState;
		next_cardSelect_n = cardSelect_n;
		unique case (cycState)
			CYC_IDLE: begin
				if (ioCycle && (claimHit != 2'b00)) begin
					next_cycState = CYC_SELECT;
					next_cardSelect_n = ~claimHit;
				end else if (ioCycle) begin
					next_cycState = CYC_MISS;
				end
			end
			CYC_SELECT, CYC_MISS: begin
				if (!ioCycle) begin
					next_cycState = CYC_IDLE;
					next_cardSelect_n = 2'b11;
				end
			end
			default: begin
				next_cycState = CYC_IDLE;
				next_cardSelect_n = 2'b11;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cycState <= CYC_IDLE;
			cardSelect_n <= 2'b11;
		end else begin
			cycState <= next_cycState;
			cardSelect_n <= next_cardSelect_n;
		end
	end

	// ***************************************
	// buffer enables and 16-bit sampling
	// ***************************************
	for (genvar i = 0; i < 2; i++) begin : g_slot
		assign dataBufEnable[i] = !cardSelect_n[i]
			&& (!rangeReg[i][`PCW_RANGE_ACKMSK] || !inputAck_n[i]);

		pcw_io16_sampler u_sampler (
			.clk_sys     (clk_sys),
			.rst         (rst),
			.relaxed     (relaxedEn),
			.addrAnchor  (ioCycle && claimHit[i] && cycState == CYC_IDLE
				|| !cardSelect_n[i]),
			.selAnchor   (!cardSelect_n[i]),
			.ioIs16_n    (ioIs16_n[i]),
			.sampleValid (io16Valid[i]),
			.sampleWide  (io16Wide[i])
		);
	end

	// ***************************************
	// checks
	// ***************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence legacyStart;
		$rose(ioCycle) && cycState == CYC_IDLE && claimHit[0] && !relaxedEn;
	endsequence
	sequence relaxedStart;
		$fell(cardSelect_n[0]) && relaxedEn;
	endsequence

	chk_buf_ack_off: assert property (!cardSelect_n[0] && !rangeReg[0][0] |-> dataBufEnable[0])
		else $error("buffer not enabled with ack ignored");
	chk_buf_ack_gate: assert property (rangeReg[1][0] |-> dataBufEnable[1]
		== (!cardSelect_n[1] && !inputAck_n[1]))
		else $error("buffer enable not gated by card ack");
	chk_ack_honour: assert property (rangeReg[0][0] && inputAck_n[0] |-> !dataBufEnable[0])
		else $error("card ack not honoured");
	chk_range_reset: assert property ($past(rst) |-> rangeReg[0] == 8'h00 && rangeReg[1] == 8'h00)
		else $error("range mask not cleared by reset");
	chk_enh_reset: assert property ($past(rst) |-> !relaxedEn && enh2 == 8'h00)
		else $error("enhancement not cleared by reset");
	chk_window_enable: assert property ($fell(cardSelect_n[0]) |-> $past(rangeReg[0][1]))
		else $error("disabled window was claimed");
	chk_claim_match: assert property (cycState == CYC_IDLE && ioCycle && claimHit[0]
		|=> !cardSelect_n[0])
		else $error("matching cycle not claimed");
	chk_legacy_sample: assert property (legacyStart ##0 $stable(relaxedEn)
		|-> !io16Valid[0] ##2 io16Valid[0])
		else $error("legacy sample point wrong");
	chk_relaxed_sample: assert property (relaxedStart ##1 relaxedEn && !cardSelect_n[0]
		|-> ##1 io16Valid[0])
		else $error("relaxed sample point wrong");

endmodule

`default_nettype wire

// ===== verification/pcw_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcw_card_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// slot bus
	input  wire logic       ioCycle,
	input  wire logic [1:0] cardSelect_n,
	output logic      [1:0] inputAck_n,
	output logic      [1:0] ioIs16_n,
	// card behaviour per slot
	input  wire logic [1:0] wide,
	input  wire logic [1:0] slow,
	input  wire logic [1:0] ackOn
);
	logic [1:0] selSeen;
	logic [1:0] next_selSeen;

	// ************
	// card lines
	// ************
	always_comb begin
		next_selSeen = rst ? 2'h0 : ~cardSelect_n;
		for (int i = 0; i < 2; i++) begin
			// released lines sit at the pull-up level
			inputAck_n[i] = !(ackOn[i] && !cardSelect_n[i]);
			ioIs16_n[i] = 1'b1;
			if (!slow[i] && ioCycle) begin
				ioIs16_n[i] = !wide[i];
			end
			// slow card qualifies with chip select, one cycle late
			if (slow[i] && selSeen[i] && !cardSelect_n[i]) begin
				ioIs16_n[i] = !wide[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		selSeen <= next_selSeen;
	end
endmodule

`default_nettype wire

// ===== verification/test_pcw_io_window_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcw_map.svh"

module test_pcw_io_window_decode;
	import pcw_pkg::*;
	logic         clk_sys;
	logic         rst;
	logic [7:0]   s_axi_awaddr;
	logic         s_axi_awvalid;
	logic         s_axi_awready;
	logic [31:0]  s_axi_wdata;
	logic [3:0]   s_axi_wstrb;
	logic         s_axi_wvalid;
	logic         s_axi_wready;
	logic [1:0]   s_axi_bresp;
	logic         s_axi_bvalid;
	logic         s_axi_bready;
	logic [7:0]   s_axi_araddr;
	logic         s_axi_arvalid;
	logic         s_axi_arready;
	logic [31:0]  s_axi_rdata;
	logic [1:0]   s_axi_rresp;
	logic         s_axi_rvalid;
	logic         s_axi_rready;
	logic         ioCycle;
	pcw_addr_type ioAddr;
	logic [1:0]   cardSelect_n, inputAck_n, dataBufEnable, ioIs16_n, io16Valid, io16Wide;
	logic [1:0]   wide, slow, ackOn;
	int           errors, comparisons, cycles;

	pcw_io_window_decode u_pcw_io_window_decode (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ioCycle(ioCycle),
		.ioAddr(ioAddr), .cardSelect_n(cardSelect_n), .inputAck_n(inputAck_n),
		.dataBufEnable(dataBufEnable), .ioIs16_n(ioIs16_n), .io16Valid(io16Valid),
		.io16Wide(io16Wide)
	);

	pcw_card_model u_pcw_card_model (
		.clk_sys(clk_sys), .rst(rst), .ioCycle(ioCycle), .cardSelect_n(cardSelect_n),
		.inputAck_n(inputAck_n), .ioIs16_n(ioIs16_n), .wide(wide), .slow(slow), .ackOn(ackOn)
	);

	// ************
	// tasks
	// ************
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// handshakes judged on settled values half a cycle before the edge
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expR);
		logic awT;
		logic wT;
		logic bT;
		logic [1:0] respV;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			awT = s_axi_awvalid && s_axi_awready;
			wT = s_axi_wvalid && s_axi_wready;
			bT = s_axi_bvalid;
			respV = s_axi_bresp;
			@(posedge clk_sys);
			if (awT) s_axi_awvalid <= 1'b0;
			if (wT) s_axi_wvalid <= 1'b0;
		end while (!bT);
		chk("bresp", expR, respV);
		s_axi_bready <= 1'b0;
	endtask

	task rdChk(input logic [7:0] a, input logic [31:0] expD, input logic [1:0] expR);
		logic arT;
		logic rT;
		logic [31:0] dataV;
		logic [1:0] respV;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			arT = s_axi_arvalid && s_axi_arready;
			rT = s_axi_rvalid;
			dataV = s_axi_rdata;
			respV = s_axi_rresp;
			@(posedge clk_sys);
			if (arT) s_axi_arvalid <= 1'b0;
		end while (!rT);
		chk("rdata", expD, dataV);
		chk("rresp", expR, respV);
		s_axi_rready <= 1'b0;
	endtask

	task io(input pcw_addr_type a, input logic [1:0] expSel, input logic [1:0] expBuf,
			input int expN, input logic expWide, input int s);
		int validN;
		logic [1:0] selV;
		logic [1:0] bufV;
		validN = 0;
		@(posedge clk_sys);
		ioAddr <= a;
		ioCycle <= 1'b1;
		for (int n = 1; n < 7; n++) begin
			@(negedge clk_sys);
			if (n == 2) begin
				selV = cardSelect_n;
				bufV = dataBufEnable;
			end
			if (io16Valid[s] && validN == 0) validN = n;
		end
		@(posedge clk_sys);
		ioCycle <= 1'b0;
		chk("select", expSel, selV);
		chk("buffers", expBuf, bufV);
		chk("sample time", expN, validN);
		if (expN != 0) chk("width", expWide, io16Wide[s]);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("release", 2'b11, cardSelect_n);
	endtask

	task endTest(input string t);
		$display("test %s finished", t);
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end

	// ************
	// tests
	// ************
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, ioCycle, ioAddr, slow, ackOn} = '0;
		s_axi_wstrb = 4'hf;
		wide = 2'b11;
		errors = 0;
		comparisons = 0;
		cycles = 0;
		rst = 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rdChk(8'(i * 4), 32'h0, 2'b00);
		wr(`PCW_OFS_RANGE0, 32'hff, 2'b00);
		rdChk(`PCW_OFS_RANGE0, 32'hfb, 2'b00);
		wr(`PCW_OFS_ENH2, 32'hff, 2'b00);
		rdChk(`PCW_OFS_ENH2, 32'h1f, 2'b00);
		wr(8'h1c, 32'h1, 2'b10);
		rdChk(8'h1c, 32'h0, 2'b10);
		wr(`PCW_OFS_ENH2, 32'h0, 2'b00);
		endTest("registers");
		wr(`PCW_OFS_BASE0, 32'h0300, 2'b00);
		for (int k = 0; k < 6; k++) begin
			wr(`PCW_OFS_RANGE0, 32'(((1 << k) - 1) << 3) | 32'h2, 2'b00);
			io(16'h0300 + 16'((8 << k) - 1), 2'b10, 2'b01, 3, 1'b1, 0);
			io(16'h0300 + 16'(8 << k), 2'b11, 2'b00, 0, 1'b0, 0);
		end
		wr(`PCW_OFS_RANGE0, 32'hf8, 2'b00);
		io(16'h0300, 2'b11, 2'b00, 0, 1'b0, 0);
		endTest("window");
		wr(`PCW_OFS_BASE1, 32'h0400, 2'b00);
		wr(`PCW_OFS_RANGE1, 32'h02, 2'b00);
		io(16'h0405, 2'b01, 2'b10, 3, 1'b1, 1);
		wr(`PCW_OFS_RANGE1, 32'h03, 2'b00);
		io(16'h0405, 2'b01, 2'b00, 3, 1'b1, 1);
		@(posedge clk_sys);
		ackOn <= 2'b10;
		io(16'h0405, 2'b01, 2'b10, 3, 1'b1, 1);
		endTest("acknowledge");
		wr(`PCW_OFS_RANGE0, 32'h02, 2'b00);
		@(posedge clk_sys);
		slow <= 2'b01;
		io(16'h0300, 2'b10, 2'b01, 3, 1'b0, 0);
		wr(`PCW_OFS_ENH2, 32'h02, 2'b00);
		io(16'h0300, 2'b10, 2'b01, 3, 1'b0, 0);
		wr(`PCW_OFS_ENH1, 32'h80, 2'b00);
		io(16'h0300, 2'b10, 2'b01, 4, 1'b1, 0);
		@(posedge clk_sys);
		slow <= 2'b00;
		wide <= 2'b10;
		io(16'h0300, 2'b10, 2'b01, 4, 1'b0, 0);
		endTest("sampling");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		rdChk(`PCW_OFS_ENH1, 32'h0, 2'b00);
		rdChk(`PCW_OFS_ENH2, 32'h0, 2'b00);
		endTest("second reset");
		give_verdict();
	end
endmodule

`default_nettype wire
